/* hdl/cdec_comm_debug.sv */
// Purpose: Comm port debug flags and frame counters behind a byte register port.
// Assumes: All event inputs are one-cycle pulses from logic on clk_sys.
// Notes: Reads answer one cycle after the strobe; the port never stalls.

// How it works
// - Direction 1: low-side command sets unexpected flag
// - Command CRC discard sets flag, hides other errors
// - Direction 0: low-side response sets unexpected flag
// - Response CRC discard sets flag, hides most errors
// - Byte error on last CRC byte: both flags
// - UART discard count, 8 bits, at 0x789
// - High-side discard count, 8 bits, at 0x78A
// - Low-side discard count, 8 bits, at 0x78B
// - Discard read latches counts, clears running counters
// - Valid count 16 bits, hi/lo, saturates
module cdec_comm_debug (
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Per-port frame outcome pulses
  input wire logic uart_frame_valid,
  input wire logic uart_frame_discard,
  input wire logic high_frame_valid,
  input wire logic high_frame_discard,
  input wire logic low_frame_valid,
  input wire logic low_frame_discard,
  // Low-side chain port command receive events
  input wire logic low_cmd_frame_rx,
  input wire logic low_cmd_crc_discard,
  // Low-side chain port response receive events
  input wire logic low_rsp_frame_rx,
  input wire logic low_rsp_crc_discard,
  input wire logic low_rsp_byte_err,
  input wire logic low_rsp_last_crc_byte,
  input wire logic low_rsp_sof_err,
  input wire logic low_rsp_txdis_err,
  input wire logic low_transmit_wait_flag_evt,
  // Status out to the comm logic
  output logic dir_sel,
  output logic comm_error
);

  // Decode helpers

  // One-hot select of the discard counter that an address names
  function automatic logic [2:0] disc_sel(input logic [11:0] addr);
    logic [2:0] sel;
    sel = 3'h0;
    sel[cdec_pkg::PORT_UART] = (addr == cdec_pkg::OFS_UART_DISC);
    sel[cdec_pkg::PORT_HIGH] = (addr == cdec_pkg::OFS_HIGH_DISC);
    sel[cdec_pkg::PORT_LOW] = (addr == cdec_pkg::OFS_LOW_DISC);
    return sel;
  endfunction

  // True when an address names one single-byte register
  function automatic logic is_flag_reg(input logic [11:0] addr, input logic [11:0] ofs);
    return addr == ofs;
  endfunction

  // Declarations

  logic ctrl_dir_sel_q;
  logic [2:0] rd_disc_sel;
  logic [2:0] port_valid_evt;
  logic [2:0] port_discard_evt;
  logic [7:0] disc_run [3];
  logic [15:0] valid_snap [3];
  logic [cdec_pkg::RSP_FLAGS_W-1:0] rsp_set;
  logic [cdec_pkg::RSP_FLAGS_W-1:0] rsp_flags;
  logic [cdec_pkg::CMD_FLAGS_W-1:0] cmd_set;
  logic [cdec_pkg::CMD_FLAGS_W-1:0] cmd_flags;
  logic rsp_clr;
  logic cmd_clr;
  logic rsp_crc_hit;
  logic rsp_last_byte_err;
  logic rsp_other_ok;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic comm_error_q;
  logic hit_ctrl;
  logic hit_cmd_diag;
  logic hit_rsp_diag;
  logic ctrl_wr;
  logic cmd_unexp_evt;
  logic rsp_unexp_evt;
  logic rsp_byte_err_evt;
  logic rsp_sof_evt;
  logic rsp_txdis_evt;
  logic rsp_transmit_wait_flag_evt;

  // Control register

  // Single-register hits, shared by the write and the clear-on-read sides
  assign hit_ctrl = is_flag_reg(reg_addr, cdec_pkg::OFS_CTRL);
  assign hit_cmd_diag = is_flag_reg(reg_addr, cdec_pkg::OFS_CMD_DIAG);
  assign hit_rsp_diag = is_flag_reg(reg_addr, cdec_pkg::OFS_RSP_DIAG);

  // Only the control register takes writes; the rest are read-only
  assign ctrl_wr = reg_wr && hit_ctrl;

  // Direction select steers which frame type is legal on the low side
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_dir_sel_q <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl_dir_sel_q <= reg_wdata[cdec_pkg::CTRL_DIR_SEL_BIT];
    end
  end

  assign dir_sel = ctrl_dir_sel_q;

  // Command diagnostics

  // Arrival is only unexpected when the frame survived its CRC check
  assign cmd_unexp_evt = ctrl_dir_sel_q && low_cmd_frame_rx && !low_cmd_crc_discard;

  // A CRC discard wins the frame; the unexpected flag would be noise
  always_comb begin
    cmd_set = '0;
    cmd_set[cdec_pkg::CMD_CRC_BIT] = low_cmd_crc_discard;
    cmd_set[cdec_pkg::CMD_UNEXP_BIT] = cmd_unexp_evt;
  end

  // Reading clears the flags; a set in that cycle still lands
  assign cmd_clr = reg_rd && hit_cmd_diag;

  cdec_sticky_flags #(
    .W(cdec_pkg::CMD_FLAGS_W)
  ) u_cmd_flags (
    .clk_sys(clk_sys),
    .rst(rst),
    .set_evt(cmd_set),
    .clr(cmd_clr),
    .flags_q(cmd_flags)
  );

  // Response diagnostics

  // A CRC discard hides most errors in the same frame
  assign rsp_crc_hit = low_rsp_crc_discard;
  assign rsp_other_ok = !rsp_crc_hit;

  // A broken final CRC byte still reports as a CRC error too
  assign rsp_last_byte_err = low_rsp_byte_err && low_rsp_last_crc_byte;

  // Unexpected needs direction 0, byte errors count in either; SOF and TX-disable only mean something at 1
  assign rsp_unexp_evt = !ctrl_dir_sel_q && low_rsp_frame_rx && rsp_other_ok;
  assign rsp_byte_err_evt = rsp_last_byte_err || (low_rsp_byte_err && rsp_other_ok);
  assign rsp_sof_evt = ctrl_dir_sel_q && low_rsp_sof_err && rsp_other_ok;

  // Not frame content, so a CRC discard does not mask these two
  assign rsp_txdis_evt = ctrl_dir_sel_q && low_rsp_txdis_err;
  assign rsp_transmit_wait_flag_evt = low_transmit_wait_flag_evt;

  // Pack the events into their flag positions
  always_comb begin
    rsp_set = '0;
    rsp_set[cdec_pkg::RSP_CRC_BIT] = rsp_crc_hit || rsp_last_byte_err;
    rsp_set[cdec_pkg::RSP_UNEXP_BIT] = rsp_unexp_evt;
    rsp_set[cdec_pkg::RSP_BYTE_ERR_BIT] = rsp_byte_err_evt;
    rsp_set[cdec_pkg::RSP_SOF_BIT] = rsp_sof_evt;
    rsp_set[cdec_pkg::RSP_TXDIS_BIT] = rsp_txdis_evt;
    rsp_set[cdec_pkg::RSP_TRANSMIT_WAIT_FLAG_BIT] = rsp_transmit_wait_flag_evt;
  end

  // Reading clears the flags; a set in that cycle still lands
  assign rsp_clr = reg_rd && hit_rsp_diag;

  cdec_sticky_flags #(
    .W(cdec_pkg::RSP_FLAGS_W)
  ) u_rsp_flags (
    .clk_sys(clk_sys),
    .rst(rst),
    .set_evt(rsp_set),
    .clr(rsp_clr),
    .flags_q(rsp_flags)
  );

  // Frame counters

  // Gather the per-port pulses into vectors for the generate loop
  assign port_valid_evt = {low_frame_valid, high_frame_valid, uart_frame_valid};
  assign port_discard_evt = {low_frame_discard, high_frame_discard, uart_frame_discard};

  // A read strobe on a discard counter snapshots and clears its port
  assign rd_disc_sel = reg_rd ? disc_sel(reg_addr) : 3'h0;

  // One counter pair per port; UART, high side, low side
  generate
    for (genvar p = 0; p < cdec_pkg::NUM_PORTS; p++) begin : g_port
      cdec_port_counter u_cnt (
        .clk_sys(clk_sys),
        .rst(rst),
        .discard_evt(port_discard_evt[p]),
        .valid_evt(port_valid_evt[p]),
        .snap_clear(rd_disc_sel[p]),
        .disc_run_q(disc_run[p]),
        .disc_snap_q(), // Unused: the discard read returns the same count live
        .valid_snap_q(valid_snap[p])
      );
    end
  endgenerate

  // Read path

  // The discard read returns the count it is latching, so the snapshot
  // and the returned byte always agree even with an event in that cycle.
  always_comb begin
    rdata_d = cdec_pkg::REG_RESET;
    case (reg_addr)
      cdec_pkg::OFS_RSP_DIAG: begin
        rdata_d[cdec_pkg::RSP_FLAGS_W-1:0] = rsp_flags;
      end
      cdec_pkg::OFS_UART_DISC: begin
        rdata_d = disc_run[cdec_pkg::PORT_UART];
      end
      cdec_pkg::OFS_HIGH_DISC: begin
        rdata_d = disc_run[cdec_pkg::PORT_HIGH];
      end
      cdec_pkg::OFS_LOW_DISC: begin
        rdata_d = disc_run[cdec_pkg::PORT_LOW];
      end
      cdec_pkg::OFS_UART_VHI: begin
        rdata_d = valid_snap[cdec_pkg::PORT_UART][15:8];
      end
      cdec_pkg::OFS_UART_VLO: begin
        rdata_d = valid_snap[cdec_pkg::PORT_UART][7:0];
      end
      cdec_pkg::OFS_HIGH_VHI: begin
        rdata_d = valid_snap[cdec_pkg::PORT_HIGH][15:8];
      end
      cdec_pkg::OFS_HIGH_VLO: begin
        rdata_d = valid_snap[cdec_pkg::PORT_HIGH][7:0];
      end
      cdec_pkg::OFS_LOW_VHI: begin
        rdata_d = valid_snap[cdec_pkg::PORT_LOW][15:8];
      end
      cdec_pkg::OFS_LOW_VLO: begin
        rdata_d = valid_snap[cdec_pkg::PORT_LOW][7:0];
      end
      cdec_pkg::OFS_CTRL: begin
        rdata_d[cdec_pkg::CTRL_DIR_SEL_BIT] = ctrl_dir_sel_q;
      end
      cdec_pkg::OFS_CMD_DIAG: begin
        rdata_d[cdec_pkg::CMD_FLAGS_W-1:0] = cmd_flags;
      end
      default: begin
        rdata_d = cdec_pkg::REG_RESET; // Unmapped reads as zero
      end
    endcase
  end

  // Read data stands for exactly the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= cdec_pkg::REG_RESET;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= cdec_pkg::REG_RESET;
    end
  end

  assign reg_rdata = rdata_q;

  // Summary status

  // Registered so the comm logic sees a clean level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      comm_error_q <= 1'b0;
    end else begin
      comm_error_q <= (|rsp_flags) || (|cmd_flags);
    end
  end

  assign comm_error = comm_error_q;

endmodule // cdec_comm_debug

/* hdl/cdec_pkg.sv */
// Purpose: Shared constants for the comm debug error counter bank.
// Assumes: Byte-wide register port, one core clock, active-high async reset.
// Notes: Offsets are byte addresses on the plain register port.
package cdec_pkg;

  // Register port geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int VALID_W = 16;

  // Port indices for the per-port counter instances
  localparam int NUM_PORTS = 3;
  localparam int PORT_UART = 0;
  localparam int PORT_HIGH = 1;
  localparam int PORT_LOW = 2;

  // Register offsets
  localparam logic [11:0] OFS_RSP_DIAG = 12'h788;
  localparam logic [11:0] OFS_UART_DISC = 12'h789;
  localparam logic [11:0] OFS_HIGH_DISC = 12'h78A;
  localparam logic [11:0] OFS_LOW_DISC = 12'h78B;
  localparam logic [11:0] OFS_UART_VHI = 12'h78C;
  localparam logic [11:0] OFS_UART_VLO = 12'h78D;
  localparam logic [11:0] OFS_HIGH_VHI = 12'h78E;
  localparam logic [11:0] OFS_HIGH_VLO = 12'h78F;
  localparam logic [11:0] OFS_LOW_VHI = 12'h790;
  localparam logic [11:0] OFS_LOW_VLO = 12'h791;
  localparam logic [11:0] OFS_CTRL = 12'h7F0;
  localparam logic [11:0] OFS_CMD_DIAG = 12'h7F1;

  // Response diagnostic field positions (bits 7:6 reserved)
  localparam int RSP_CRC_BIT = 0;
  localparam int RSP_UNEXP_BIT = 1;
  localparam int RSP_BYTE_ERR_BIT = 2;
  localparam int RSP_SOF_BIT = 3;
  localparam int RSP_TXDIS_BIT = 4;
  localparam int RSP_TRANSMIT_WAIT_FLAG_BIT = 5;
  localparam int RSP_FLAGS_W = 6;

  // Command diagnostic and control field positions
  localparam int CMD_CRC_BIT = 0;
  localparam int CMD_UNEXP_BIT = 1;
  localparam int CMD_FLAGS_W = 2;
  localparam int CTRL_DIR_SEL_BIT = 0;

  // Reset and limit values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] DISC_MAX = 8'hFF;
  localparam logic [7:0] DISC_ONE = 8'h01;
  localparam logic [15:0] VALID_RESET = 16'h0000;
  localparam logic [15:0] VALID_MAX = 16'hFFFF;
  localparam logic [15:0] VALID_ONE = 16'h0001;

endpackage

/* hdl/cdec_port_counter.sv */
// Purpose: Discard and valid frame counters for one comm port.
// Assumes: Event pulses are one cycle, on clk_sys.
// Notes: snap_clear copies running counts to the readable copies.
module cdec_port_counter (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic discard_evt,
  input wire logic valid_evt,
  input wire logic snap_clear,
  output logic [7:0] disc_run_q,
  output logic [7:0] disc_snap_q,
  output logic [15:0] valid_snap_q
);

  logic [15:0] valid_run_q;

  // Discard count saturates; an event during the clear counts as one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      disc_run_q <= cdec_pkg::REG_RESET;
    end else if (snap_clear) begin
      disc_run_q <= discard_evt ? cdec_pkg::DISC_ONE : cdec_pkg::REG_RESET;
    end else if (discard_evt && disc_run_q != cdec_pkg::DISC_MAX) begin
      disc_run_q <= disc_run_q + cdec_pkg::DISC_ONE;
    end
  end

  // Valid count, 16 bits, held at all ones
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      valid_run_q <= cdec_pkg::VALID_RESET;
    end else if (snap_clear) begin
      valid_run_q <= valid_evt ? cdec_pkg::VALID_ONE : cdec_pkg::VALID_RESET;
    end else if (valid_evt && valid_run_q != cdec_pkg::VALID_MAX) begin
      valid_run_q <= valid_run_q + cdec_pkg::VALID_ONE;
    end
  end

  // Readable copies taken from the pre-event running counts
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      disc_snap_q <= cdec_pkg::REG_RESET;
      valid_snap_q <= cdec_pkg::VALID_RESET;
    end else if (snap_clear) begin
      disc_snap_q <= disc_run_q;
      valid_snap_q <= valid_run_q;
    end
  end

endmodule // cdec_port_counter

/* hdl/cdec_sticky_flags.sv */
// Purpose: Bank of sticky event flags with a group clear.
// Assumes: Set and clear come from logic on clk_sys.
// Notes: A set in the clearing cycle survives the clear.
module cdec_sticky_flags #(
  parameter int W = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] set_evt,
  input wire logic clr,
  output logic [W-1:0] flags_q
);

  // Set wins over clear so no event is lost
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~{W{clr}}) | set_evt;
    end
  end

endmodule // cdec_sticky_flags

/* testbench/cdec_comm_debug_properties.sv */
// Purpose: Port-level checks of the debug flag and counter bank.
// Assumes: Single clk_sys domain, rst async active high.
// Notes: Flag checks read one cycle after the event pulse.
module cdec_comm_debug_properties (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic uart_frame_discard,
  input wire logic high_frame_discard,
  input wire logic low_frame_discard,
  input wire logic low_cmd_frame_rx,
  input wire logic low_cmd_crc_discard,
  input wire logic low_rsp_frame_rx,
  input wire logic low_rsp_crc_discard,
  input wire logic low_rsp_byte_err,
  input wire logic low_rsp_last_crc_byte,
  input wire logic dir_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Reads of the two flag registers
  sequence s_cmd_rd; reg_rd && reg_addr == 12'h7F1; endsequence
  sequence s_rsp_rd; reg_rd && reg_addr == 12'h788; endsequence
  // Discard read with no same-cycle discard, then the same read again
  sequence s_disc_rd;
    reg_rd && reg_addr inside {12'h789, 12'h78A, 12'h78B} &&
      !uart_frame_discard && !high_frame_discard && !low_frame_discard;
  endsequence
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_unexp_cmd_flag: assert property (dir_sel && low_cmd_frame_rx && !low_cmd_crc_discard ##1 s_cmd_rd
    |=> reg_rdata[1]) else $error("unexpected command flag missing");
  a_cmd_crc_flag: assert property (low_cmd_crc_discard ##1 s_cmd_rd |=> reg_rdata[0])
    else $error("command crc flag missing");
  a_unexp_rsp_flag: assert property (!dir_sel && low_rsp_frame_rx && !low_rsp_crc_discard ##1 s_rsp_rd
    |=> reg_rdata[1]) else $error("unexpected response flag missing");
  a_rsp_crc_flag: assert property (low_rsp_crc_discard ##1 s_rsp_rd |=> reg_rdata[0])
    else $error("response crc flag missing");
  a_last_crc_both: assert property (low_rsp_byte_err && low_rsp_last_crc_byte ##1 s_rsp_rd
    |=> reg_rdata[0] && reg_rdata[2]) else $error("last crc byte error not doubly flagged");
  a_disc_read_clears: assert property (s_disc_rd ##1 reg_rd && $stable(reg_addr)
    |=> reg_rdata == 8'h00) else $error("discard counter not cleared by read");
  a_dir_write: assert property (reg_wr && reg_addr == 12'h7F0 |=> dir_sel == $past(reg_wdata[0]))
    else $error("direction select not written");
  a_dir_hold: assert property (!(reg_wr && reg_addr == 12'h7F0) |=> $stable(dir_sel))
    else $error("direction select changed without write");
endmodule // cdec_comm_debug_properties

/* testbench/cdec_frame_src.sv */
// Purpose: Far-side source of frame outcome and receive-error pulses.
// Assumes: Bench drives go and pat right after a rising edge.
// Notes: Pulses stand one cycle per sampled go, idle low otherwise.
module cdec_frame_src (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go,
  input wire logic [14:0] pat,
  output logic [14:0] evt_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // Registered so every event lands cleanly on the next core edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      evt_q <= 15'h0000;
    end else begin
      evt_q <= go ? pat : 15'h0000;
    end
  end
endmodule // cdec_frame_src

/* testbench/tb_cdec_comm_debug.sv */
// Purpose: Self-checking bench for the comm debug flag and counter bank.
// Assumes: Event bits 0..14 follow the design's event port order.
// Notes: Flag registers clear on read, so each check reads once.
module tb_cdec_comm_debug;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic go = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [14:0] pat = 15'h0000;
  logic [14:0] evt;
  logic dir_sel;
  logic comm_error;
  int error_cnt = 0;
  int samples_checked = 0;
  cdec_frame_src cdec_frame_src_inst (.clk_sys(clk_sys), .rst(rst), .go(go), .pat(pat), .evt_q(evt));
  cdec_comm_debug cdec_comm_debug_inst (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .uart_frame_valid(evt[0]), .uart_frame_discard(evt[1]),
    .high_frame_valid(evt[2]), .high_frame_discard(evt[3]), .low_frame_valid(evt[4]),
    .low_frame_discard(evt[5]), .low_cmd_frame_rx(evt[6]), .low_cmd_crc_discard(evt[7]),
    .low_rsp_frame_rx(evt[8]), .low_rsp_crc_discard(evt[9]), .low_rsp_byte_err(evt[10]),
    .low_rsp_last_crc_byte(evt[11]), .low_rsp_sof_err(evt[12]), .low_rsp_txdis_err(evt[13]),
    .low_transmit_wait_flag_evt(evt[14]), .dir_sel(dir_sel), .comm_error(comm_error));
  // Free-running core clock
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One register write, one cycle strobe
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // One read, answer checked in the single cycle it stands
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string n);
    @(posedge clk_sys);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, e);
  endtask
  // Hold an event pattern for n cycles
  task automatic pulse(input logic [14:0] p, input int n);
    @(posedge clk_sys);
    go <= 1'b1; pat <= p;
    repeat (n) @(posedge clk_sys);
    go <= 1'b0;
  endtask
  task automatic s_reset();
    for (int i = 0; i < 10; i++) rd(12'h788 + 12'(i), 8'h00, "reset value");
    rd(cdec_pkg::OFS_CTRL, 8'h00, "ctrl reset");
    rd(cdec_pkg::OFS_CMD_DIAG, 8'h00, "cmd diag reset");
    wr(cdec_pkg::OFS_UART_DISC, 8'h5A);
    rd(cdec_pkg::OFS_UART_DISC, 8'h00, "discard read only");
    rd(12'h000, 8'h00, "unmapped read");
  endtask
  // Back-to-back discard reads: latched value, then cleared count
  task automatic s_counts();
    for (int p = 0; p < 3; p++) begin
      pulse(15'h0003 << (2 * p), p + 2);
      @(posedge clk_sys);
      reg_rd <= 1'b1; reg_addr <= cdec_pkg::OFS_UART_DISC + 12'(p);
      @(posedge clk_sys);
      #1 chk("discard count", reg_rdata, 8'(p + 2));
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk("discard cleared", reg_rdata, 8'h00);
      rd(cdec_pkg::OFS_UART_VLO + 12'(2 * p), 8'h00, "valid relatched");
      pulse(15'h0001 << (2 * p), p + 3);
      rd(cdec_pkg::OFS_UART_DISC + 12'(p), 8'h00, "no discards");
      rd(cdec_pkg::OFS_UART_VHI + 12'(2 * p), 8'h00, "valid hi");
      rd(cdec_pkg::OFS_UART_VLO + 12'(2 * p), 8'(p + 3), "valid lo");
    end
  endtask
  // 300 frames: discard sticks at its top, valid carries into hi byte
  task automatic s_sat();
    pulse(15'h0003, 300);
    rd(cdec_pkg::OFS_UART_DISC, 8'hFF, "discard saturated");
    rd(cdec_pkg::OFS_UART_VHI, 8'h01, "valid hi carry");
    rd(cdec_pkg::OFS_UART_VLO, 8'h2C, "valid lo carry");
  endtask
  task automatic s_flags();
    pulse(15'h3140, 1);
    rd(cdec_pkg::OFS_RSP_DIAG, 8'h02, "rsp unexpected dir0");
    chk("comm error set", {7'h00, comm_error}, 8'h01);
    rd(cdec_pkg::OFS_CMD_DIAG, 8'h00, "cmd ok dir0");
    chk("comm error clear", {7'h00, comm_error}, 8'h00);
    pulse(15'h0700, 1);
    rd(cdec_pkg::OFS_RSP_DIAG, 8'h01, "rsp crc hides rest");
    pulse(15'h0C00, 1);
    rd(cdec_pkg::OFS_RSP_DIAG, 8'h05, "last crc byte");
    wr(cdec_pkg::OFS_CTRL, 8'h01);
    #1 chk("dir select", {7'h00, dir_sel}, 8'h01);
    pulse(15'h0140, 1);
    rd(cdec_pkg::OFS_CMD_DIAG, 8'h02, "cmd unexpected dir1");
    rd(cdec_pkg::OFS_RSP_DIAG, 8'h00, "rsp ok dir1");
    pulse(15'h00C0, 1);
    rd(cdec_pkg::OFS_CMD_DIAG, 8'h01, "cmd crc hides rest");
    pulse(15'h7000, 1);
    rd(cdec_pkg::OFS_RSP_DIAG, 8'h38, "sof txdis wait dir1");
    pulse(15'h7200, 1);
    rd(cdec_pkg::OFS_RSP_DIAG, 8'h31, "crc masks sof only");
  endtask
  // Watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    s_reset();
    s_counts();
    s_sat();
    s_flags();
    test_done();
  end
endmodule // tb_cdec_comm_debug
bind cdec_comm_debug cdec_comm_debug_properties cdec_comm_debug_properties_inst (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .uart_frame_discard(uart_frame_discard),
  .high_frame_discard(high_frame_discard), .low_frame_discard(low_frame_discard),
  .low_cmd_frame_rx(low_cmd_frame_rx), .low_cmd_crc_discard(low_cmd_crc_discard),
  .low_rsp_frame_rx(low_rsp_frame_rx), .low_rsp_crc_discard(low_rsp_crc_discard),
  .low_rsp_byte_err(low_rsp_byte_err), .low_rsp_last_crc_byte(low_rsp_last_crc_byte), .dir_sel(dir_sel));
